/* File: bench/frou_mem_model.sv */
// behavioural main storage on the far side of the float unit's word port
// assumes the unit's clock; words addressed by the low 8 address bits
`timescale 1ns/1ns
module frou_mem_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // request from the unit
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  // wait states before each ack, 0 answers at once
  input wire logic [3:0] wait_in,
  // answer
  output logic ack_out,
  output logic [15:0] rdata_out
);
  logic [15:0] mem_q [0:255]; // storage words
  logic [3:0] wait_q; // cycles waited on this word
  logic [15:0] last_q; // last word shown
  // ack once the wait states have run out
  assign ack_out = req_in && (wait_q == wait_in);
  // stale data is inverted so it never passes for valid
  assign rdata_out = ack_out ? mem_q[addr_in[7:0]] : ~last_q;
  // wait counting; writes land at the acking edge
  always @(posedge clk_in) begin
    if (reset_in) begin
      wait_q <= 4'h0;
      last_q <= 16'h0000;
    end else if (ack_out) begin
      wait_q <= 4'h0;
      last_q <= rdata_out;
      if (we_in) mem_q[addr_in[7:0]] <= wdata_in;
    end else if (req_in) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // frou_mem_model

/* File: bench/frou_unit_chk.sv */
// assertion checker for the float register ops unit, bound to its ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`include "frou_defs.vh"
module frou_unit_chk (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // requests
  input wire logic op_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic [15:0] eff_addr_in,
  input wire logic [15:0] exc_addr_in,
  // storage
  input wire logic mem_ack_in,
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] mem_wdata_out,
  // results
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic exc_branch_out,
  input wire logic [15:0] branch_addr_out,
  input wire logic gr_wr_en_out,
  input wire logic [3:0] cond_out,
  input wire logic [63:0] fpr_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  logic take; // request accepted at this edge
  logic [15:0] exc_q; // exception address of the running op
  logic [1:0] words_q; // words acked so far
  assign take = op_valid_in && !busy_out;
  // latch the op's branch target, count words
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      exc_q <= 16'h0000;
      words_q <= 2'h0;
    end else if (take) begin
      exc_q <= exc_addr_in;
      // a conversion writes one word only, so start at the last count
      words_q <= (op_code_in == `FROU_OP_TOINT) ? 2'h3 : 2'h0;
    end else if (mem_req_out && mem_ack_in) begin
      words_q <= words_q + 2'h1;
    end
  end
  pulse_excl_a: assert property (!(done_out && exc_branch_out))
    else $error("done and branch together");
  busy_drop_a: assert property ((done_out || exc_branch_out) |-> !busy_out && $past(busy_out))
    else $error("busy not ended with pulse");
  branch_addr_a: assert property (exc_branch_out |-> branch_addr_out == exc_q && cond_out[0])
    else $error("branch target or flag wrong");
  neg_flip_a: assert property (take && op_code_in == `FROU_OP_NEG |=>
    fpr_out == ($past(fpr_out) ^ 64'h8000_0000_0000_0000) && $stable(cond_out) ##1 done_out)
    else $error("negate result wrong");
  first_word_a: assert property (take && op_code_in <= `FROU_OP_STORE |=> mem_req_out &&
    mem_addr_out == $past(eff_addr_in) && mem_we_out == ($past(op_code_in) == `FROU_OP_STORE))
    else $error("first word address wrong");
  word_step_a: assert property (mem_req_out && mem_ack_in && words_q != 2'h3 |=>
    mem_req_out && mem_addr_out == $past(mem_addr_out) + 16'h0001)
    else $error("word address did not step");
  store_order_a: assert property (take && op_code_in == `FROU_OP_STORE |=>
    mem_wdata_out == fpr_out[63:48])
    else $error("store did not start with top word");
  gr_then_done_a: assert property (gr_wr_en_out |=> done_out)
    else $error("register write not followed by done");
  toint_keep_a: assert property (take && op_code_in == `FROU_OP_TOINT |=> $stable(fpr_out)[*2])
    else $error("conversion altered register");
  cond_one_a: assert property ($onehot0(cond_out[3:1]))
    else $error("sign flags not exclusive");
  cover property (exc_branch_out);
  cover property (gr_wr_en_out);
  cover property (take && op_code_in == `FROU_OP_STORE);
endmodule // frou_unit_chk
bind frou_unit frou_unit_chk u_chk (.core_clk_in(core_clk_in), .reset_in(reset_in),
  .op_valid_in(op_valid_in), .op_code_in(op_code_in), .eff_addr_in(eff_addr_in), .exc_addr_in(exc_addr_in),
  .mem_ack_in(mem_ack_in), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
  .mem_wdata_out(mem_wdata_out), .busy_out(busy_out), .done_out(done_out), .exc_branch_out(exc_branch_out),
  .branch_addr_out(branch_addr_out), .gr_wr_en_out(gr_wr_en_out), .cond_out(cond_out), .fpr_out(fpr_out));

/* File: bench/frou_unit_tb.sv */
// self-checking bench for the float register ops unit
// assumes the unit, its checker and the storage model compile alongside
`timescale 1ns/1ns
`include "frou_defs.vh"
module frou_unit_tb;
  // request drive
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  logic [2:0] op_code = 3'h7;
  logic ind = 1'b0;
  logic [15:0] eff_addr = 16'h0000;
  logic [15:0] exc_addr = 16'h0000;
  logic [3:0] wt = 4'h0; // storage wait states, rotated per op
  // unit outputs
  logic mem_ack, mem_req, mem_we, busy, done, exc_br, gr_en;
  logic [15:0] mem_rdata, mem_addr, mem_wdata, br_addr, gr_data;
  logic [3:0] cond;
  logic [63:0] fpr;
  logic [15:0] gr_seen; // last register write seen
  logic saw_exc; // op ended by branch
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  frou_unit DUT (.core_clk_in(clk), .reset_in(rst), .op_valid_in(op_valid), .op_code_in(op_code),
    .indirect_in(ind), .eff_addr_in(eff_addr), .exc_addr_in(exc_addr), .mem_ack_in(mem_ack),
    .mem_rdata_in(mem_rdata), .mem_req_out(mem_req), .mem_we_out(mem_we), .mem_addr_out(mem_addr),
    .mem_wdata_out(mem_wdata), .busy_out(busy), .done_out(done), .exc_branch_out(exc_br),
    .branch_addr_out(br_addr), .gr_wr_en_out(gr_en), .gr_wr_data_out(gr_data), .cond_out(cond), .fpr_out(fpr));
  frou_mem_model m (.clk_in(clk), .reset_in(rst), .req_in(mem_req), .we_in(mem_we), .addr_in(mem_addr),
    .wdata_in(mem_wdata), .wait_in(wt), .ack_out(mem_ack), .rdata_out(mem_rdata));
  // catch register writes; watchdog against hangs
  always @(posedge clk) begin
    if (gr_en === 1'b1) gr_seen <= gr_data;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // four words, top word at the lowest address
  task automatic put_fp(input logic [15:0] a, input logic [63:0] v);
    for (int i = 0; i < 4; i++) m.mem_q[a[7:0] + i] = v[63 - 16 * i -: 16];
  endtask
  // present one op for a single take, then wait for its pulse
  task automatic run_op(input logic [2:0] code, input logic i, input logic [15:0] a);
    int n;
    n = 0;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= code;
    ind <= i;
    eff_addr <= a;
    exc_addr <= ~a;
    wt <= (wt == 4'h2) ? 4'h0 : wt + 4'h1;
    @(posedge clk);
    op_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n = n + 1;
    end while (done !== 1'b1 && exc_br !== 1'b1 && n < 200);
    // no completion within the limit counts as a failure
    if (done !== 1'b1 && exc_br !== 1'b1) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
    saw_exc = exc_br;
    if (saw_exc === 1'b1) chk({48'h0, br_addr}, {48'h0, ~a});
  endtask
  // preload the register unless the op is a load, run one op on a memory operand, check outcome
  task automatic fp_case(input logic [2:0] code, input logic i, input logic [63:0] pre, input logic [63:0] opnd,
                         input logic [63:0] exp, input logic [3:0] cc, input logic ex);
    if (code != `FROU_OP_LOAD) begin
      put_fp(16'h0030, pre);
      run_op(`FROU_OP_LOAD, 1'b0, 16'h0030);
    end
    put_fp(16'h0010, opnd);
    run_op(code, i, 16'h0010);
    chk(fpr, exp);
    chk({60'h0, cond}, {60'h0, cc});
    chk({63'h0, saw_exc}, {63'h0, ex});
  endtask
  // conversion: result lands in register or memory, none on exception
  task automatic int_case(input logic i, input logic [63:0] pre, input logic [15:0] v, input logic [3:0] cc,
                          input logic ex);
    gr_seen = ~v;
    fp_case(`FROU_OP_TOINT, i, pre, {~v, 48'h0}, pre, cc, ex);
    chk({48'h0, i ? m.mem_q[16] : gr_seen}, {48'h0, ex ? ~v : v});
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(fpr, 64'h0);
    fp_case(`FROU_OP_LOAD, 0, 0, 64'h4100_1234_0000_0000, 64'h3F12_3400_0000_0000, 4'h2, 0);
    fp_case(`FROU_OP_LOAD, 0, 0, 64'hC210_0000_0000_0000, 64'hC210_0000_0000_0000, 4'h4, 0);
    fp_case(`FROU_OP_LOAD, 0, 0, 64'h4500_0000_0000_0000, 64'h0, 4'h8, 0);
    fp_case(`FROU_OP_LOAD, 0, 0, 64'h8000_1000_0000_0000, 64'hFE10_0000_0000_0000, 4'h5, 1);
    fp_case(`FROU_OP_MUL, 0, 64'h4120 << 48, 64'hC130 << 48, 64'hC160 << 48, 4'h4, 0);
    fp_case(`FROU_OP_MUL, 0, 64'h7F10 << 48, 64'h7F10 << 48, 64'h3D10 << 48, 4'h9, 1);
    fp_case(`FROU_OP_MUL, 0, 64'h7F10 << 48, 64'h4110 << 48, 64'h7F10 << 48, 4'h2, 0);
    fp_case(`FROU_OP_MUL, 0, 64'h0010 << 48, 64'h4010 << 48, 64'h7F10 << 48, 4'h5, 1);
    fp_case(`FROU_OP_MUL, 0, 64'h4110 << 48, 64'h4200 << 48, 64'h0, 4'h8, 0);
    fp_case(`FROU_OP_SUB, 0, 64'h4120 << 48, 64'h4110 << 48, 64'h4110 << 48, 4'h2, 0);
    fp_case(`FROU_OP_SUB, 0, 64'h4120 << 48, 64'h4120 << 48, 64'h0, 4'h8, 0);
    fp_case(`FROU_OP_SUB, 0, 64'h41F0_0000_0000_0001, 64'hC110 << 48, 64'h4210 << 48, 4'h2, 0);
    fp_case(`FROU_OP_SUB, 0, 64'h7FF0 << 48, 64'hFF20 << 48, 64'h0011 << 48, 4'h9, 1);
    fp_case(`FROU_OP_ADD, 0, 64'h4120 << 48, 64'h4110 << 48, 64'h4130 << 48, 4'h2, 0);
    fp_case(`FROU_OP_NEG, 0, 64'h4120 << 48, 64'h0, 64'hC120 << 48, 4'h2, 0);
    fp_case(`FROU_OP_NEG, 0, 64'hC210 << 48, 64'h0, 64'h4210 << 48, 4'h4, 0);
    fp_case(3'h7, 0, 64'h4120 << 48, 64'h0, 64'h4120 << 48, 4'h2, 0);
    fp_case(`FROU_OP_STORE, 0, 64'h4412_3456_789A_BCDE, 64'h0, 64'h4412_3456_789A_BCDE, 4'h2, 0);
    chk({m.mem_q[16], m.mem_q[17], m.mem_q[18], m.mem_q[19]}, 64'h4412_3456_789A_BCDE);
    int_case(0, 64'h4412_3400_0000_0000, 16'h1234, 4'h2, 0);
    int_case(1, 64'hC412_3400_0000_0000, 16'hEDCC, 4'h4, 0);
    int_case(0, 64'h4312_3800_0000_0000, 16'h0123, 4'h2, 0);
    int_case(0, 64'h4480 << 48, 16'h8000, 4'h1, 1);
    int_case(0, 64'hC480 << 48, 16'h8000, 4'h4, 0);
    int_case(1, 64'h0, 16'h0000, 4'h8, 0);
    stop_test();
  end
endmodule // frou_unit_tb

/* File: include/frou_defs.vh */
// constants for the floating point register ops unit
// assumes the including file is plain verilog; definitions only
`ifndef FROU_DEFS_VH
`define FROU_DEFS_VH
// operation codes on op_code_in
`define FROU_OP_ADD 3'h0
`define FROU_OP_SUB 3'h1
`define FROU_OP_MUL 3'h2
`define FROU_OP_LOAD 3'h3
`define FROU_OP_STORE 3'h4
`define FROU_OP_NEG 3'h5
`define FROU_OP_TOINT 3'h6
// field positions inside the 64-bit register
`define FROU_SIGN_BIT 63
`define FROU_EXP_HI 62
`define FROU_EXP_LO 56
`define FROU_FRAC_HI 55
// exponent bias and biased limits (10-bit signed working values)
`define FROU_EXP_BIAS 10'h040
`define FROU_EXP_MAX 10'h07F
// integer limits
`define FROU_INT_POS_MAX 16'h7FFF
`define FROU_INT_NEG_MAX 16'h8000
// condition bit indices (index equals printed bit number)
`define FROU_CC_EXC 0
`define FROU_CC_POS 1
`define FROU_CC_NEG 2
`define FROU_CC_ZERO 3
// words in a floating operand, minus one
`define FROU_LAST_WORD 2'h3
`endif

/* File: rtl/frou_multiplier.v */
// fraction and exponent multiplier for two register-format operands
// assumes operands are stable through the parent's execute cycle
`timescale 1ns/1ns
`include "frou_defs.vh"
module frou_multiplier (
  // operands
  input wire [63:0] a_in,
  input wire [63:0] b_in,
  // product
  output wire [59:0] frac_out,
  output wire [9:0] exp_out,
  output wire sign_out
);
  wire [111:0] full; // 28-digit raw product
  assign full = a_in[`FROU_FRAC_HI:0] * b_in[`FROU_FRAC_HI:0];
  // keep top 15 digits; normalizer drops the guard digit
  assign frac_out = full[111:52];
  // biased sum minus bias
  assign exp_out = {3'h0, a_in[`FROU_EXP_HI:`FROU_EXP_LO]} + {3'h0, b_in[`FROU_EXP_HI:`FROU_EXP_LO]}
    - `FROU_EXP_BIAS;
  // signed-number rule for the product sign
  assign sign_out = a_in[`FROU_SIGN_BIT] ^ b_in[`FROU_SIGN_BIT];
endmodule // frou_multiplier

/* File: rtl/frou_normalizer.v */
// hex-digit normalizer for a 15-digit working fraction
// assumes a combinational use inside the execute cycle of the parent
`timescale 1ns/1ns
`include "frou_defs.vh"
module frou_normalizer (
  // working value
  input wire [59:0] frac_in,
  input wire [9:0] exp_in,
  // normalized value
  output reg [55:0] frac_out,
  output reg [9:0] exp_out,
  output reg zero_out
);
  reg [59:0] shifted; // fraction after left shift
  reg [3:0] lead; // count of leading zero digits
  integer i;
  // count leading zero digits, shift, then truncate the guard digit
  always @* begin
    lead = 4'h0;
    shifted = frac_in;
    zero_out = (frac_in == 60'h0);
    // scan upward from the bottom digit; the last hit is the leading digit
    for (i = 14; i >= 0; i = i - 1) begin
      if (frac_in[(59 - i * 4) -: 4] != 4'h0) begin
        lead = i[3:0];
      end
    end
    shifted = frac_in << {lead, 2'b00};
    frac_out = shifted[59:4]; // truncation, no rounding
    exp_out = exp_in - {6'h00, lead};
  end
endmodule // frou_normalizer

/* File: rtl/frou_unit.v */
// floating point register ops unit: load, store, add/subtract,
// multiply, negate and float-to-int, with condition bits
// assumes the sequencer supplies the effective address (after indexing
// and indirection) and the exception-address register contents
`timescale 1ns/1ns
`include "frou_defs.vh"
module frou_unit (
  // clock and reset
  input wire core_clk_in,
  input wire reset_in,
  // operation request from the sequencer
  input wire op_valid_in,
  input wire [2:0] op_code_in,
  input wire indirect_in,
  input wire [15:0] eff_addr_in,
  input wire [15:0] exc_addr_in,
  // main storage
  input wire mem_ack_in,
  input wire [15:0] mem_rdata_in,
  output wire mem_req_out,
  output wire mem_we_out,
  output wire [15:0] mem_addr_out,
  output wire [15:0] mem_wdata_out,
  // completion and branch
  output wire busy_out,
  output wire done_out,
  output wire exc_branch_out,
  output wire [15:0] branch_addr_out,
  // general register write (first named register)
  output wire gr_wr_en_out,
  output wire [15:0] gr_wr_data_out,
  // architectural state
  output wire [3:0] cond_out,
  output wire [63:0] fpr_out
);
  // sequencing states
  localparam ST_IDLE = 3'h0;
  localparam ST_READ = 3'h1;
  localparam ST_EXEC = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_FIN = 3'h4;

  reg [2:0] state_q; // sequencer state
  reg [2:0] op_q; // latched operation
  reg ind_q; // latched indirect flag
  reg [15:0] exc_addr_q; // latched exception address
  reg [63:0] opd_q; // memory operand being assembled
  reg [63:0] fpr_q; // floating point register
  reg [3:0] cond_q; // condition bits 0..3
  reg [1:0] cnt_q; // word counter
  reg [1:0] last_q; // last word index of the transfer
  reg exc_q; // pending exception for this op
  reg req_q; // memory request
  reg we_q; // memory write
  reg [15:0] addr_q; // memory word address
  reg [15:0] wdata_q; // memory write data
  reg busy_q; // unit occupied
  reg done_q; // clean completion pulse
  reg exc_br_q; // exception branch pulse
  reg [15:0] br_addr_q; // branch target
  reg gr_we_q; // general register write pulse
  reg [15:0] gr_data_q; // general register write data

  // pick one 16-bit word of a register image, word 0 most significant
  function [15:0] word_sel;
    input [63:0] img;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: word_sel = img[63:48];
        2'h1: word_sel = img[47:32];
        2'h2: word_sel = img[31:16];
        default: word_sel = img[15:0];
      endcase
    end
  endfunction

  // operand fields
  wire sa = fpr_q[`FROU_SIGN_BIT];
  wire [6:0] ea = fpr_q[`FROU_EXP_HI:`FROU_EXP_LO];
  wire [55:0] fa = fpr_q[`FROU_FRAC_HI:0];
  // subtract inverts the memory operand sign first
  wire sb = opd_q[`FROU_SIGN_BIT] ^ (op_q == `FROU_OP_SUB);
  wire [6:0] eb = opd_q[`FROU_EXP_HI:`FROU_EXP_LO];
  wire [55:0] fb = opd_q[`FROU_FRAC_HI:0];

  // multiplier
  wire [59:0] mul_frac;
  wire [9:0] mul_exp;
  wire mul_sign;
  frou_multiplier u_mul (
    .a_in(fpr_q),
    .b_in(opd_q),
    .frac_out(mul_frac),
    .exp_out(mul_exp),
    .sign_out(mul_sign)
  );

  // add path: align to the larger exponent with one guard digit
  reg a_big; // register operand has the larger or equal exponent
  reg [6:0] dexp; // exponent difference
  reg [59:0] big_f; // aligned larger-exponent fraction
  reg [59:0] sml_f; // aligned smaller-exponent fraction
  reg big_s; // sign of larger-exponent operand
  reg sml_s; // sign of smaller-exponent operand
  reg [60:0] sum; // sum with carry digit position
  reg add_sign; // sign of the sum
  reg [59:0] add_frac; // sum after carry shift
  reg [9:0] add_exp; // exponent after carry shift
  reg add_carry_ovf; // overflow from the carry shift
  always @* begin
    a_big = (ea >= eb);
    dexp = a_big ? (ea - eb) : (eb - ea);
    big_f = a_big ? {fa, 4'h0} : {fb, 4'h0};
    sml_f = a_big ? {fb, 4'h0} : {fa, 4'h0};
    big_s = a_big ? sa : sb;
    sml_s = a_big ? sb : sa;
    // shifted past all 15 digits means nothing is left
    sml_f = (dexp >= 7'h0F) ? 60'h0 : (sml_f >> ({3'h0, dexp} * 10'h004));
    if (big_s == sml_s) begin
      sum = {1'b0, big_f} + {1'b0, sml_f};
      add_sign = big_s;
    end else if (big_f >= sml_f) begin
      sum = {1'b0, big_f} - {1'b0, sml_f};
      add_sign = big_s;
    end else begin
      sum = {1'b0, sml_f} - {1'b0, big_f};
      add_sign = sml_s;
    end
    // carry out: one digit right, exponent up
    if (sum[60]) begin
      add_frac = {3'h0, sum[60:4]};
      add_exp = {3'h0, (a_big ? ea : eb)} + 10'h001;
    end else begin
      add_frac = sum[59:0];
      add_exp = {3'h0, (a_big ? ea : eb)};
    end
    add_carry_ovf = $signed(add_exp) > $signed(`FROU_EXP_MAX);
  end

  // normalizer input chosen by operation
  reg [59:0] nrm_in_frac;
  reg [9:0] nrm_in_exp;
  reg nrm_sign;
  always @* begin
    case (op_q)
      `FROU_OP_LOAD: begin
        nrm_in_frac = {fb, 4'h0}; // unnormalized source allowed
        nrm_in_exp = {3'h0, eb};
        nrm_sign = opd_q[`FROU_SIGN_BIT];
      end
      `FROU_OP_MUL: begin
        nrm_in_frac = mul_frac;
        nrm_in_exp = mul_exp;
        nrm_sign = mul_sign;
      end
      default: begin
        nrm_in_frac = add_frac; // add and subtract
        nrm_in_exp = add_exp;
        nrm_sign = add_sign;
      end
    endcase
  end

  wire [55:0] nrm_frac;
  wire [9:0] nrm_exp;
  wire nrm_zero;
  frou_normalizer u_nrm (
    .frac_in(nrm_in_frac),
    .exp_in(nrm_in_exp),
    .frac_out(nrm_frac),
    .exp_out(nrm_exp),
    .zero_out(nrm_zero)
  );

  // range checks on the final exponent; zero never traps
  // overflow is judged after normalization, and for add/subtract also on the carry shift
  wire res_ovf = !nrm_zero && ($signed(nrm_exp) > $signed(`FROU_EXP_MAX)
    || (op_q != `FROU_OP_MUL && op_q != `FROU_OP_LOAD && add_carry_ovf));
  wire res_unf = !nrm_zero && $signed(nrm_exp) < $signed(10'h000);
  // exponent field wraps mod 128: too large/small by 128
  wire [63:0] res_img = nrm_zero ? 64'h0 : {nrm_sign, nrm_exp[6:0], nrm_frac};

  // float-to-int: truncate toward zero
  wire [9:0] int_e = {3'h0, ea} - `FROU_EXP_BIAS;
  reg [15:0] int_mag; // magnitude before sign
  reg int_ovf; // out of integer range
  reg [15:0] int_val; // two's-complement result
  always @* begin
    int_mag = 16'h0000;
    int_ovf = 1'b0;
    if (fa == 56'h0 || $signed(int_e) <= $signed(10'h000)) begin
      int_mag = 16'h0000; // pure fraction truncates to zero
    end else if ($signed(int_e) > $signed(10'h004)) begin
      int_ovf = 1'b1; // at least 16^4 in magnitude
    end else begin
      int_mag = fa[55:40] >> ((10'h004 - int_e) * 10'h004);
      int_ovf = sa ? (int_mag > `FROU_INT_NEG_MAX) : (int_mag > `FROU_INT_POS_MAX);
    end
    int_val = sa ? (16'h0000 - int_mag) : int_mag;
  end

  // condition bits from a sign and zero flag
  function [3:0] cc_sz;
    input neg;
    input zero;
    begin
      cc_sz = 4'h0;
      cc_sz[`FROU_CC_ZERO] = zero;
      cc_sz[`FROU_CC_POS] = !zero && !neg;
      cc_sz[`FROU_CC_NEG] = !zero && neg;
    end
  endfunction

  // sequencer: accept, fetch operand, execute, write, finish
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      op_q <= 3'h0;
      ind_q <= 1'b0;
      exc_addr_q <= 16'h0000;
      opd_q <= 64'h0;
      fpr_q <= 64'h0;
      cond_q <= 4'h0;
      cnt_q <= 2'h0;
      last_q <= 2'h0;
      exc_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      exc_br_q <= 1'b0;
      br_addr_q <= 16'h0000;
      gr_we_q <= 1'b0;
      gr_data_q <= 16'h0000;
    end else begin
      // pulses last one cycle
      done_q <= 1'b0;
      exc_br_q <= 1'b0;
      gr_we_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (op_valid_in) begin
            op_q <= op_code_in;
            ind_q <= indirect_in;
            exc_addr_q <= exc_addr_in;
            exc_q <= 1'b0;
            busy_q <= 1'b1;
            cnt_q <= 2'h0;
            addr_q <= eff_addr_in; // most significant word first
            case (op_code_in)
              `FROU_OP_STORE: begin
                req_q <= 1'b1;
                we_q <= 1'b1;
                last_q <= `FROU_LAST_WORD;
                wdata_q <= word_sel(fpr_q, 2'h0);
                state_q <= ST_WRITE;
              end
              `FROU_OP_NEG: begin
                fpr_q[`FROU_SIGN_BIT] <= ~fpr_q[`FROU_SIGN_BIT]; // condition untouched
                state_q <= ST_FIN;
              end
              `FROU_OP_TOINT: begin
                state_q <= ST_EXEC;
              end
              `FROU_OP_ADD, `FROU_OP_SUB, `FROU_OP_MUL, `FROU_OP_LOAD: begin
                req_q <= 1'b1;
                we_q <= 1'b0;
                last_q <= `FROU_LAST_WORD;
                state_q <= ST_READ;
              end
              default: begin
                state_q <= ST_FIN; // unused code does nothing
              end
            endcase
          end
        end
        ST_READ: begin
          // shift words in, most significant first
          if (mem_ack_in) begin
            opd_q <= {opd_q[47:0], mem_rdata_in};
            cnt_q <= cnt_q + 2'h1;
            addr_q <= addr_q + 16'h0001;
            if (cnt_q == last_q) begin
              req_q <= 1'b0;
              state_q <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (op_q == `FROU_OP_TOINT) begin
            if (int_ovf) begin
              cond_q <= 4'h1 << `FROU_CC_EXC;
              exc_q <= 1'b1;
              state_q <= ST_FIN;
            end else begin
              cond_q <= cc_sz(int_val[15], int_val == 16'h0000);
              // register untouched, result to register or memory
              if (ind_q) begin
                req_q <= 1'b1;
                we_q <= 1'b1;
                last_q <= 2'h0;
                cnt_q <= 2'h0;
                wdata_q <= int_val;
                state_q <= ST_WRITE;
              end else begin
                gr_we_q <= 1'b1;
                gr_data_q <= int_val;
                state_q <= ST_FIN;
              end
            end
          end else begin
            fpr_q <= res_img;
            if (res_unf) begin
              cond_q <= (4'h1 << `FROU_CC_EXC) | (4'h1 << `FROU_CC_NEG);
              exc_q <= 1'b1;
            end else if (res_ovf) begin
              cond_q <= (4'h1 << `FROU_CC_EXC) | (4'h1 << `FROU_CC_ZERO);
              exc_q <= 1'b1;
            end else begin
              cond_q <= cc_sz(nrm_sign, nrm_zero);
            end
            state_q <= ST_FIN;
          end
        end
        ST_WRITE: begin
          // one word per acknowledge, ascending addresses
          if (mem_ack_in) begin
            cnt_q <= cnt_q + 2'h1;
            addr_q <= addr_q + 16'h0001;
            wdata_q <= word_sel(fpr_q, cnt_q + 2'h1);
            if (cnt_q == last_q) begin
              req_q <= 1'b0;
              we_q <= 1'b0;
              state_q <= ST_FIN;
            end
          end
        end
        ST_FIN: begin
          // exception branches away, otherwise next fetch
          done_q <= !exc_q;
          exc_br_q <= exc_q;
          br_addr_q <= exc_q ? exc_addr_q : 16'h0000;
          busy_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE; // recover from a stray code
          busy_q <= 1'b0;
          req_q <= 1'b0;
          we_q <= 1'b0;
        end
      endcase
    end
  end

  // outputs straight from flip-flops
  assign mem_req_out = req_q;
  assign mem_we_out = we_q;
  assign mem_addr_out = addr_q;
  assign mem_wdata_out = wdata_q;
  assign busy_out = busy_q;
  assign done_out = done_q;
  assign exc_branch_out = exc_br_q;
  assign branch_addr_out = br_addr_q;
  assign gr_wr_en_out = gr_we_q;
  assign gr_wr_data_out = gr_data_q;
  assign cond_out = cond_q;
  assign fpr_out = fpr_q;
endmodule // frou_unit
